// ### src/dmac_block.sv
// Notes on behaviour
// - One of four modes selected.
// - Eight 9-bit or four 18-bit products.
// - Dynamic operand signs, optionally registered.
// - Input and result registers selectable separately.
// - 36x36 sums four partial products.
// - Pipeline registers before the summation stage.
// - 36x36 correct signed and unsigned.
// - Two independent 18-bit multiply accumulators.
// - Accumulator 52 bits, 34 in 9-bit.
// - Load control loads product, 0-2 registers.
// - Overflow flag clears at next accumulation.
// - Per-half add or subtract each cycle.
// - Pair sums: two wide, four narrow.
// - Complex product via subtract and add halves.
// - Final stage sums both adder units.
// - Input registers chain data and coefficients.
// - Four-tap 18-bit FIR, cascade outside.
// - Add select high adds, low subtracts.
// - Unsigned only when both signs low.
// - Load high drops feedback, restarts accumulation.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "dmac_defs.svh"

module dmac_block (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [71:0] op_a,
   input wire logic [71:0] op_b,
   input wire logic sign_a,
   input wire logic sign_b,
   input wire logic [1:0] add_sel,
   input wire logic [1:0] acc_load,
   input wire logic coef_load,
   input wire logic [17:0] shift_data_in,
   input wire logic [17:0] shift_coef_in,
   output logic [17:0] shift_data_out,
   output logic [17:0] shift_coef_out,
   output logic [143:0] result,
   output logic [1:0] overflow
);
   logic [`DMAC_CTRL_USED_W-1:0] ctrl;
   dmac_pkg::dmac_mode_type mode;
   logic narrow;
   logic wide36;
   logic in_reg;
   logic pipe_reg;
   logic out_reg;
   logic sign_reg;
   logic [1:0] sload_stages;
   logic shift_on;
   logic coef_ser;
   logic sa_q;
   logic sb_q;
   logic sa;
   logic sb;
   logic [17:0] a_q [4];
   logic [17:0] b_q [4];
   logic [17:0] a_in [4];
   logic [17:0] b_in [4];
   logic [39:0] p_c [4];
   logic [39:0] p_q [4];
   logic [39:0] p [4];
   logic [71:0] sum36;
   logic [1:0] sload_d1;
   logic [1:0] sload_d2;
   logic [1:0] sload;
   logic [51:0] acc [2];
   logic [53:0] next_ext [2];
   logic [1:0] next_ovf;
   logic [71:0] slot [2];
   logic [143:0] res_q;
   logic [40:0] pair_w [2];
   logic [20:0] pair_lo [2];
   logic [20:0] pair_hi [2];
   logic [41:0] quad_w;
   logic [21:0] quad_lo;
   logic [21:0] quad_hi;

   // Configuration fields decoded from the control register.
   assign mode = dmac_pkg::dmac_mode_type'(ctrl[`DMAC_CTRL_MODE_LSB +: 2]);
   assign narrow = ctrl[`DMAC_CTRL_NARROW];
   assign wide36 = ctrl[`DMAC_CTRL_WIDE36] && mode == dmac_pkg::DMAC_SIMPLE && !narrow;
   assign in_reg = ctrl[`DMAC_CTRL_IN_REG];
   assign pipe_reg = ctrl[`DMAC_CTRL_PIPE_REG];
   assign out_reg = ctrl[`DMAC_CTRL_OUT_REG];
   assign sign_reg = ctrl[`DMAC_CTRL_SIGN_REG];
   assign sload_stages = ctrl[`DMAC_CTRL_SLOAD_LSB +: 2];
   // The internal chain is withheld at 36 bits; the fabric shifts those operands itself.
   assign shift_on = ctrl[`DMAC_CTRL_SHIFT_EN] && !wide36;
   assign coef_ser = ctrl[`DMAC_CTRL_COEF_SER];

   // Control register write; the register port never stalls.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `DMAC_CTRL_RESET;
      end else if (reg_wr && reg_addr == `DMAC_OFF_CTRL) begin
         ctrl <= reg_wdata[`DMAC_CTRL_USED_W-1:0];
      end
   end

   // Read data stand one cycle after the strobe and only then; unmapped reads give zero.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 32'h0;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0;
      end else if (reg_addr == `DMAC_OFF_CTRL) begin
         reg_rdata <= {20'h0, ctrl};
      end else if (reg_addr == `DMAC_OFF_STAT) begin
         reg_rdata <= {26'h0, mode, 2'h0, overflow};
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // Optional sign control registers; both low means unsigned.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sa_q <= 1'b0;
         sb_q <= 1'b0;
      end else begin
         sa_q <= sign_a;
         sb_q <= sign_b;
      end
   end
   assign sa = sign_reg ? sa_q : sign_a;
   assign sb = sign_reg ? sb_q : sign_b;

   // Load control delayed by zero, one or two registers.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sload_d1 <= 2'h0;
         sload_d2 <= 2'h0;
      end else begin
         sload_d1 <= acc_load;
         sload_d2 <= sload_d1;
      end
   end
   assign sload = sload_stages == 2'h0 ? acc_load :
                  sload_stages == 2'h1 ? sload_d1 : sload_d2;

   assign shift_data_out = a_q[3];
   assign shift_coef_out = b_q[3];

   // Per-multiplier input registers, shift chains, operand routing and products.
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_mul
         logic sa_m;
         logic sb_m;
         logic [17:0] a_m;
         logic [17:0] b_m;

         // Data and coefficient chains feed tap 0 from outside and each tap from the last.
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               a_q[i] <= 18'h0;
               b_q[i] <= 18'h0;
            end else if (shift_on) begin
               a_q[i] <= (i == 0) ? shift_data_in : a_q[(i + 3) % 4];
               if (coef_ser) begin
                  b_q[i] <= (i == 0) ? shift_coef_in : b_q[(i + 3) % 4];
               end else if (coef_load) begin
                  b_q[i] <= op_b[i*18 +: 18];
               end
            end else begin
               a_q[i] <= op_a[i*18 +: 18];
               b_q[i] <= op_b[i*18 +: 18];
            end
         end
         assign a_in[i] = (in_reg || shift_on) ? a_q[i] : op_a[i*18 +: 18];
         assign b_in[i] = (in_reg || shift_on) ? b_q[i] : op_b[i*18 +: 18];

         // At 36 bits the low halves are unsigned and only the high halves carry sign.
         assign a_m = wide36 ? a_in[i % 2] : a_in[i];
         assign b_m = wide36 ? b_in[i / 2] : b_in[i];
         assign sa_m = wide36 ? (sa && (i % 2) == 1) : sa;
         assign sb_m = wide36 ? (sb && i >= 2) : sb;

         dmac_mult u_mult (
            .a(a_m),
            .b(b_m),
            .sa(sa_m),
            .sb(sb_m),
            .narrow(narrow),
            .prod(p_c[i])
         );

         // Optional pipeline register at the multiplier output.
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               p_q[i] <= 40'h0;
            end else begin
               p_q[i] <= p_c[i];
            end
         end
         assign p[i] = pipe_reg ? p_q[i] : p_c[i];
      end
   endgenerate

   // Summation of the four partial products into one 72-bit product.
   assign sum36 = {{32{p[0][39]}}, p[0]} + ({{32{p[1][39]}}, p[1]} << 18) +
                  ({{32{p[2][39]}}, p[2]} << 18) + ({{32{p[3][39]}}, p[3]} << 36);

   // Two adder units, each also able to act as an accumulator.
   genvar h;
   generate
      for (h = 0; h < 2; h++) begin : g_half
         logic sgn;
         logic [53:0] acc_x;
         logic [53:0] fb;
         logic [53:0] px;
         logic [39:0] q0;
         logic [39:0] q1;

         assign q0 = p[2*h];
         assign q1 = p[2*h+1];
         assign sgn = sa || sb;

         // Pair add or subtract; high select adds.
         assign pair_w[h] = add_sel[h] ? {q0[39], q0} + {q1[39], q1} :
                            {q0[39], q0} - {q1[39], q1};
         assign pair_lo[h] = add_sel[h] ? {q0[19], q0[19:0]} + {q1[19], q1[19:0]} :
                             {q0[19], q0[19:0]} - {q1[19], q1[19:0]};
         assign pair_hi[h] = add_sel[h] ? {q0[39], q0[39:20]} + {q1[39], q1[39:20]} :
                             {q0[39], q0[39:20]} - {q1[39], q1[39:20]};

         // Accumulator operands at the active width; narrow uses the low 9-bit lane.
         assign acc_x = narrow ? {{20{sgn & acc[h][33]}}, acc[h][33:0]} :
                        {{2{sgn & acc[h][51]}}, acc[h]};
         assign px = narrow ? {{34{q0[19]}}, q0[19:0]} : {{14{q0[39]}}, q0};
         // A high load drops the feedback so the new sum starts with this product.
         assign fb = sload[h] ? 54'h0 : acc_x;
         // A load takes the product as it stands, whatever the add select says.
         assign next_ext[h] = sload[h] ? px : add_sel[h] ? fb + px : fb - px;

         // Signed runs overflow on a sign mismatch, unsigned runs on carry or borrow.
         always_comb begin
            if (narrow) begin
               next_ovf[h] = sgn ? next_ext[h][34] != next_ext[h][33] : next_ext[h][34];
            end else begin
               next_ovf[h] = sgn ? next_ext[h][52] != next_ext[h][51] : next_ext[h][52];
            end
         end

         // The accumulator lives in the output register and runs only in accumulate mode.
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               acc[h] <= 52'h0;
            end else if (mode == dmac_pkg::DMAC_MAC) begin
               acc[h] <= narrow ? {18'h0, next_ext[h][33:0]} : next_ext[h][51:0];
            end
         end

         // Overflow holds through an accumulation and clears when the next one loads.
         // A new overflow in the loading cycle still sets the flag.
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               overflow[h] <= 1'b0;
            end else if (mode != dmac_pkg::DMAC_MAC) begin
               overflow[h] <= 1'b0;
            end else begin
               overflow[h] <= next_ovf[h] | (overflow[h] & ~sload[h]);
            end
         end
      end
   endgenerate

   // Final summation stage adds the two adder units lane by lane.
   assign quad_w = {pair_w[0][40], pair_w[0]} + {pair_w[1][40], pair_w[1]};
   assign quad_lo = {pair_lo[0][20], pair_lo[0]} + {pair_lo[1][20], pair_lo[1]};
   assign quad_hi = {pair_hi[0][20], pair_hi[0]} + {pair_hi[1][20], pair_hi[1]};

   // Result slots: each half owns 72 bits of the result bus.
   always_comb begin
      slot[0] = 72'h0;
      slot[1] = 72'h0;
      case (mode)
         dmac_pkg::DMAC_SIMPLE: begin
            if (wide36) begin
               slot[0] = sum36;
            end else if (narrow) begin
               slot[0] = {p[1][37:20], p[1][17:0], p[0][37:20], p[0][17:0]};
               slot[1] = {p[3][37:20], p[3][17:0], p[2][37:20], p[2][17:0]};
            end else begin
               slot[0] = {p[1][35:0], p[0][35:0]};
               slot[1] = {p[3][35:0], p[2][35:0]};
            end
         end
         dmac_pkg::DMAC_MAC: begin
            slot[0] = {20'h0, acc[0]};
            slot[1] = {20'h0, acc[1]};
         end
         dmac_pkg::DMAC_ADD2: begin
            if (narrow) begin
               slot[0] = {15'h0, pair_hi[0], 15'h0, pair_lo[0]};
               slot[1] = {15'h0, pair_hi[1], 15'h0, pair_lo[1]};
            end else begin
               slot[0] = {{31{pair_w[0][40]}}, pair_w[0]};
               slot[1] = {{31{pair_w[1][40]}}, pair_w[1]};
            end
         end
         default: begin
            if (narrow) begin
               slot[0] = {14'h0, quad_hi, 14'h0, quad_lo};
            end else begin
               slot[0] = {{30{quad_w[41]}}, quad_w};
            end
         end
      endcase
   end

   // Optional output register; accumulate mode already reads its own register.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         res_q <= 144'h0;
      end else begin
         res_q <= {slot[1], slot[0]};
      end
   end
   assign result = (out_reg && mode != dmac_pkg::DMAC_MAC) ? res_q : {slot[1], slot[0]};

endmodule : dmac_block

// ### src/dmac_defs.svh
`ifndef DMAC_DEFS_SVH
`define DMAC_DEFS_SVH

// Register offsets on the plain register port.
`define DMAC_OFF_CTRL 4'h0
`define DMAC_OFF_STAT 4'h4

// Control register field positions.
`define DMAC_CTRL_MODE_LSB 0
`define DMAC_CTRL_NARROW 2
`define DMAC_CTRL_WIDE36 3
`define DMAC_CTRL_IN_REG 4
`define DMAC_CTRL_PIPE_REG 5
`define DMAC_CTRL_OUT_REG 6
`define DMAC_CTRL_SIGN_REG 7
`define DMAC_CTRL_SLOAD_LSB 8
`define DMAC_CTRL_SHIFT_EN 10
`define DMAC_CTRL_COEF_SER 11
`define DMAC_CTRL_USED_W 12
`define DMAC_CTRL_RESET 12'h000

// Status register field positions.
`define DMAC_STAT_OVF_LSB 0
`define DMAC_STAT_MODE_LSB 4

// Accumulator widths: a 36-bit product plus 16 guard bits, or 34 bits for 9-bit lanes.
`define DMAC_PROD_W 36
`define DMAC_GUARD_W 16
`define DMAC_ACC_W 52
`define DMAC_ACC9_W 34

`endif

// ### src/dmac_mult.sv
`timescale 1ns/1ps

// One 18x18 multiplier that can also split into two 9x9 lanes.
// The result is two's complement: one extra bit per operand carries the sign mode.
module dmac_mult (
   input wire logic [17:0] a,
   input wire logic [17:0] b,
   input wire logic sa,
   input wire logic sb,
   input wire logic narrow,
   output logic [39:0] prod
);
   logic signed [18:0] aw;
   logic signed [18:0] bw;
   logic signed [37:0] pw;
   logic signed [9:0] al;
   logic signed [9:0] bl;
   logic signed [9:0] ah;
   logic signed [9:0] bh;
   logic signed [19:0] pl;
   logic signed [19:0] ph;

   // An operand is unsigned when its sign control is low, so its top bit extends as zero.
   assign aw = {sa & a[17], a};
   assign bw = {sb & b[17], b};
   assign al = {sa & a[8], a[8:0]};
   assign bl = {sb & b[8], b[8:0]};
   assign ah = {sa & a[17], a[17:9]};
   assign bh = {sb & b[17], b[17:9]};
   assign pw = aw * bw;
   assign pl = al * bl;
   assign ph = ah * bh;

   // Narrow packs two 20-bit lane products; wide sign-extends the 38-bit product.
   assign prod = narrow ? {ph, pl} : {{2{pw[37]}}, pw};

endmodule : dmac_mult

// ### src/dmac_pkg.sv
package dmac_pkg;

   // Operating modes, Gray coded along simple, accumulate, pair add, quad add.
   typedef enum logic [1:0] {
      DMAC_SIMPLE = 2'h0,
      DMAC_MAC = 2'h1,
      DMAC_ADD2 = 2'h3,
      DMAC_ADD4 = 2'h2
   } dmac_mode_type;

endpackage : dmac_pkg

// ### testbench/dmac_fabric.sv
`timescale 1ns/1ps

// Fabric side: feeds every multiplier lane and keeps its own overflow record.
module dmac_fabric (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic idle,
   input wire logic [17:0] keep,
   input wire logic [1:0] overflow,
   output logic [71:0] op_a,
   output logic [71:0] op_b,
   output logic [1:0] ovf_held
);
   logic [31:0] seed = 32'hA7DB2129;

   // All lanes share one mask, so summed products always have equal width.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         op_a <= 72'h0;
         op_b <= 72'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            op_a[18*i+:18] <= idle ? 18'h0 : 18'($random(seed)) & keep;
            op_b[18*i+:18] <= idle ? 18'h0 : 18'($random(seed)) & keep;
         end
      end
   end

   // The flag clears when a new sum starts, so a sticky copy is kept here.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ovf_held <= 2'h0;
      end else begin
         ovf_held <= ovf_held | overflow;
      end
   end
endmodule : dmac_fabric

// ### testbench/dmac_monitor.sv
`timescale 1ns/1ps

// Port-side checker; it shadows the control word from register writes.
module dmac_monitor (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [71:0] op_a,
   input wire logic [71:0] op_b,
   input wire logic sign_a,
   input wire logic sign_b,
   input wire logic [1:0] add_sel,
   input wire logic [1:0] acc_load,
   input wire logic [143:0] result,
   input wire logic [1:0] overflow
);
   logic [11:0] ctrl;
   logic [71:0] p [4];
   logic [71:0] s0, s1;
   logic [143:0] q;
   logic [51:0] next_acc;
   logic mac;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   // Shadow of the control word, so each check knows the configuration.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl <= 12'h000;
      end else if (reg_wr && reg_addr == 4'h0) begin
         ctrl <= reg_wdata[11:0];
      end
   end

   // Sign-extended lane products, so that sums need no further care.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         p[i] = $signed({sign_a & op_a[18*i+17], op_a[18*i+:18]})
            * $signed({sign_b & op_b[18*i+17], op_b[18*i+:18]});
      end
      s0 = add_sel[0] ? p[0] + p[1] : p[0] - p[1];
      s1 = add_sel[1] ? p[2] + p[3] : p[2] - p[3];
      q = {p[3][35:0], p[2][35:0], p[1][35:0], p[0][35:0]};
      mac = ctrl == 12'h001;
      next_acc = acc_load[0] ? p[0][51:0] : add_sel[0] ? result[51:0] + p[0][51:0]
         : result[51:0] - p[0][51:0];
   end

   a_rdata_zero: assert property (!$past(reg_rd && (reg_addr == 4'h0 || reg_addr == 4'h4))
      |-> reg_rdata == 32'h0) else $error("read data not zero");
   a_ctrl_readback: assert property ($past(reg_rd && reg_addr == 4'h0)
      |-> reg_rdata == {20'h0, $past(ctrl)}) else $error("control readback wrong");
   a_stat_readback: assert property ($past(reg_rd && reg_addr == 4'h4)
      |-> reg_rdata == {26'h0, $past(ctrl[1:0]), 2'h0, $past(overflow)})
      else $error("status readback wrong");
   a_ovf_quiet: assert property (ctrl[1:0] != 2'h1 && $past(ctrl[1:0]) != 2'h1
      |-> overflow == 2'h0) else $error("overflow outside accumulate");
   a_simple_comb: assert property (ctrl == 12'h000
      |-> result == q) else $error("simple products wrong");
   a_out_reg_delay: assert property (ctrl == 12'h040 && $past(ctrl) == 12'h040
      |-> result == $past(q)) else $error("output register delay wrong");
   a_mac_accum: assert property ($past(mac, 2) && $past(mac) && mac
      |-> result[51:0] == $past(next_acc)) else $error("accumulator wrong");
   a_ovf_borrow: assert property ($past(mac, 2) && $past(mac && !sign_a && !sign_b
      && !acc_load[0] && !add_sel[0] && result[51:0] < p[0][51:0]) && mac
      |-> overflow[0]) else $error("borrow not flagged");
   a_ovf_clear: assert property (mac && $past(mac && acc_load[0])
      |-> !overflow[0]) else $error("overflow not cleared by load");
   a_add2_pairs: assert property (ctrl == 12'h003
      |-> result == {s1, s0}) else $error("pair sums wrong");
   a_add4_sum: assert property (ctrl == 12'h002
      |-> result[71:0] == s0 + s1) else $error("quad sum wrong");
endmodule : dmac_monitor

bind dmac_block dmac_monitor dmac_monitor_inst (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .op_a, .op_b, .sign_a, .sign_b, .add_sel, .acc_load, .result, .overflow);

// ### testbench/tb.sv
`timescale 1ns/1ps

module tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sign_a = 1'b0;
   logic sign_b = 1'b0;
   logic [1:0] add_sel = 2'h0;
   logic [1:0] acc_load = 2'h0;
   logic idle = 1'b1;
   logic [17:0] keep = 18'h3FFFF;
   logic [31:0] reg_rdata;
   logic [71:0] op_a, op_b, s0, s1, w;
   logic [143:0] result;
   logic [1:0] overflow, ovf_held;
   logic [31:0] seed = 32'hA7DB2129;
   logic [71:0] p [4];
   logic [51:0] acc;
   logic eo = 1'b0;
   logic held = 1'b0;
   logic [11:0] cfg [5] = '{12'h000, 12'h003, 12'h002, 12'h008, 12'h040};
   int mismatches = 0;
   int cmp_count = 0;

   dmac_block dmac_block_inst (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .op_a, .op_b, .sign_a, .sign_b, .add_sel, .acc_load, .coef_load(1'b0),
      .shift_data_in(18'h0), .shift_coef_in(18'h0), .shift_data_out(), .shift_coef_out(),
      .result, .overflow);
   dmac_fabric dmac_fabric_inst (.clk_sys, .rstn, .idle, .keep, .overflow, .op_a, .op_b,
      .ovf_held);

   // Free-running system clock.
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   // Two's complement product; an 18-bit lane sign-extends from bit 17.
   function automatic logic [71:0] pr(input logic [35:0] a, input logic [35:0] b,
      input logic w36);
      logic [36:0] x, y;
      x = w36 ? {sign_a & a[35], a} : {{19{sign_a & a[17]}}, a[17:0]};
      y = w36 ? {sign_b & b[35], b} : {{19{sign_b & b[17]}}, b[17:0]};
      pr = $signed(x) * $signed(y);
   endfunction : pr

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_res(input logic [71:0] got, input logic [71:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_res

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe, so look there.
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk_reg(reg_rdata, e);
   endtask : rd

   task automatic report_and_stop;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // A hang is cut short well after the expected run of under two hundred cycles.
   initial begin
      repeat (3000) @(posedge clk_sys);
      mismatches++;
      report_and_stop;
   end

   // Register checks, then every mode with random operands, then accumulation.
   initial begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(4'h0, 32'h0);
      rd(4'h8, 32'h0);
      wr(4'h0, 32'hFFFFF003);
      rd(4'h0, 32'h3);
      rd(4'h4, 32'h30);
      foreach (cfg[k]) begin
         wr(4'h0, {20'h0, cfg[k]});
         for (int n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            idle <= n == 0;
            {sign_a, sign_b, add_sel} <= 4'($random(seed));
            @(negedge clk_sys);
            for (int i = 0; i < 4; i++) p[i] = pr(op_a[18*i+:18], op_b[18*i+:18], 1'b0);
            s0 = add_sel[0] ? p[0] + p[1] : p[0] - p[1];
            s1 = add_sel[1] ? p[2] + p[3] : p[2] - p[3];
            w = pr(op_a[35:0], op_b[35:0], 1'b1);
            case (cfg[k])
               12'h000: begin
                  chk_res(result[71:0], {p[1][35:0], p[0][35:0]});
                  chk_res(result[143:72], {p[3][35:0], p[2][35:0]});
               end
               12'h003: begin
                  chk_res(result[71:0], s0);
                  chk_res(result[143:72], s1);
               end
               12'h002: chk_res(result[71:0], s0 + s1);
               12'h008: chk_res(result[71:0], w);
               default: ;
            endcase
         end
      end
      wr(4'h0, 32'h1);
      for (int n = 0; n < 60; n++) begin
         @(posedge clk_sys);
         idle <= 1'b0;
         keep <= 18'h3FFC0;
         {sign_a, sign_b} <= 2'h0;
         acc_load <= {1'b1, n % 8 == 0};
         add_sel <= 2'($random(seed));
         @(negedge clk_sys);
         if (n > 0) begin
            chk_res({20'h0, result[51:0]}, {20'h0, acc});
            chk_reg({31'h0, overflow[0]}, {31'h0, eo});
         end
         w = pr(op_a[35:0], op_b[35:0], 1'b0);
         if (acc_load[0]) begin
            eo = 1'b0;
            acc = w[51:0];
         end else if (add_sel[0]) begin
            acc = acc + w[51:0];
         end else begin
            eo = eo | (acc < w[51:0]);
            acc = acc - w[51:0];
         end
         held = held | eo;
      end
      @(posedge clk_sys);
      idle <= 1'b1;
      add_sel <= 2'h3;
      acc_load <= 2'h0;
      rd(4'h4, {26'h0, 2'h1, 3'h0, eo});
      chk_reg({30'h0, ovf_held}, {31'h0, held});
      report_and_stop;
   end
endmodule : tb
